// ==== fir_bank_pkg.sv ====
`default_nettype none

package fir_bank_pkg;

  // ********************************************************
  // Filter geometry
  // ********************************************************
  localparam int NUM_TAPS   = 9;
  localparam int CENTER_TAP = 4;
  localparam int TAP_W      = 12;
  localparam int CENTER_W   = 18;
  localparam int REG_W      = 24;
  localparam int ADDR_W     = 12;
  localparam int TAP_BYTES  = 2;
  localparam int CTR_BYTES  = 3;
  localparam int GUARD_W    = 4;

  // ********************************************************
  // Register map, byte addresses, low byte first
  // ********************************************************
  localparam logic [ADDR_W-1:0] TAP_ADDR [0:NUM_TAPS-1] = '{
    12'h418, 12'h41a, 12'h41c, 12'h41e, 12'h420,
    12'h423, 12'h425, 12'h427, 12'h429
  };

  localparam logic [REG_W-1:0] TAP_RESET = 24'h00_0000;

  // ********************************************************
  // Carriers
  // ********************************************************
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
  } reg_req_s;

endpackage

`default_nettype wire

// ==== fir_tap_coeff_bank_a.sv ====
// What this block does
// R1 - Each tap weight is a signed two's-complement value in its register's low field.
// R2 - Fourth tap weight is the 12-bit field in bits 11 to 0.
// R3 - Centre register at 0x420 is 24 bits; weight 17:0, 23:18 reserved read/write.
// R4 - Fifth tap is the centre tap with 18-bit weight resolution.
// R5 - Register 0x423 holds sixth tap in 11:0; bits 15:12 reserved read/write.
// R6 - Register 0x425 holds seventh tap in 11:0; upper four bits reserved.
// R7 - Single-channel mode uses the same channel-A weights, tap for tap.
// R8 - Centre register clears to zero on reset, reserved bits included.
// R9 - Sixth tap register clears to zero on reset.
// R10 - Seventh tap register clears to zero on reset.
// R11 - Taps two to four are 12-bit signed, from 0x41A, reset to zero.
// R12 - Eighth tap is 12-bit signed in its own register, used in both modes.
// R13 - Output is sum of nine weight-sample products, current and eight preceding samples.
`default_nettype none

module fir_tap_coeff_bank_a #(
  parameter int SAMPLE_W = 8
) (
  input  wire logic                          clk,
  input  wire logic                          reset,
  input  wire fir_bank_pkg::reg_req_s        reg_req,
  output var  logic [7:0]                    rd_data,
  output var  logic                          rd_valid,
  input  wire logic                          single_channel_mode,
  input  wire logic                          in_valid,
  input  wire logic signed [SAMPLE_W-1:0]    in_sample,
  output var  logic                          out_valid,
  output var  logic                          out_single,
  output var  logic signed [SAMPLE_W+fir_bank_pkg::CENTER_W+fir_bank_pkg::GUARD_W-1:0] out_sample
);

  localparam int OUT_W = SAMPLE_W + fir_bank_pkg::CENTER_W + fir_bank_pkg::GUARD_W;
  localparam int NT    = fir_bank_pkg::NUM_TAPS;
  localparam int RW    = fir_bank_pkg::REG_W;

  // ********************************************************
  // Elaboration check
  // ********************************************************
  // The accumulator guard is sized for nine taps and modest sample widths
  if (SAMPLE_W < 2 || SAMPLE_W > 16)
  begin : g_bad_width
    $error("SAMPLE_W must lie between 2 and 16");
  end

  // The byte map and the weight extraction rely on the package geometry
  if (fir_bank_pkg::CENTER_TAP >= NT)
  begin : g_bad_center
    $error("CENTER_TAP must index one of the taps");
  end

  if (fir_bank_pkg::TAP_W > 8 * fir_bank_pkg::TAP_BYTES)
  begin : g_bad_tap_w
    $error("TAP_W must fit in the bytes of a tap register");
  end

  if (fir_bank_pkg::CENTER_W > 8 * fir_bank_pkg::CTR_BYTES)
  begin : g_bad_center_w
    $error("CENTER_W must fit in the bytes of the centre register");
  end

  // The output width is sized from the centre weight, so it must be the widest
  if (fir_bank_pkg::CENTER_W < fir_bank_pkg::TAP_W)
  begin : g_bad_center_narrow
    $error("CENTER_W must not be narrower than TAP_W");
  end

  if (RW != 8 * fir_bank_pkg::CTR_BYTES)
  begin : g_bad_reg_w
    $error("REG_W must equal the byte span of the centre register");
  end

  // Nine products need four bits of headroom above the widest one
  if ((1 << fir_bank_pkg::GUARD_W) < NT)
  begin : g_bad_guard
    $error("GUARD_W leaves too little headroom for the tap count");
  end

  // ********************************************************
  // Weight registers
  // ********************************************************
  logic [RW-1:0] tap_q [0:NT-1];
  logic [RW-1:0] tap_d [0:NT-1];
  logic [7:0]    rd_data_d;
  logic          rd_valid_d;

  // A wide weight is written a byte at a time, so the filter may briefly
  // see half old, half new; load weights while the stream is idle

  always_comb
  begin
    logic [7:0] rbyte;
    int         nbytes;
    rbyte = 8'h00;
    nbytes = 0;
    for (int i = 0; i < NT; i++)
    begin
      tap_d[i] = tap_q[i];
    end
    for (int i = 0; i < NT; i++)
    begin
      // R3 centre spans three bytes
      nbytes = (i == fir_bank_pkg::CENTER_TAP) ? fir_bank_pkg::CTR_BYTES
                                               : fir_bank_pkg::TAP_BYTES;
      for (int k = 0; k < fir_bank_pkg::CTR_BYTES; k++)
      begin
        if (k < nbytes && reg_req.addr == fir_bank_pkg::TAP_ADDR[i] + 12'(k))
        begin
          // R5 R6 reserved bits stored
          if (reg_req.wr)
          begin
            tap_d[i][8*k +: 8] = reg_req.wdata;
          end
          rbyte = tap_q[i][8*k +: 8];
        end
      end
    end
    // Unmapped reads return zero
    // A read in the same cycle as a write returns the old byte
    // Zero outside reads lets several banks share one return bus
    rd_data_d = reg_req.rd ? rbyte : 8'h00;
    rd_valid_d = reg_req.rd;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      // R8 R9 R10 R11 clear all weights
      for (int i = 0; i < NT; i++)
      begin
        tap_q[i] <= fir_bank_pkg::TAP_RESET;
      end
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < NT; i++)
      begin
        tap_q[i] <= tap_d[i];
      end
      rd_data <= rd_data_d;
      rd_valid <= rd_valid_d;
    end
  end

  // ********************************************************
  // Filter datapath
  // ********************************************************
  logic signed [SAMPLE_W-1:0] hist_q [0:NT-2];
  logic signed [SAMPLE_W-1:0] hist_d [0:NT-2];
  logic signed [OUT_W-1:0]    acc_d;
  logic                       out_valid_d;
  logic                       out_single_d;
  logic signed [OUT_W-1:0]    out_sample_d;

  always_comb
  begin
    logic signed [OUT_W-1:0]    coef;
    logic signed [OUT_W-1:0]    smp;
    logic signed [SAMPLE_W-1:0] cur;
    coef = '0;
    smp = '0;
    cur = '0;
    acc_d = '0;
    // Full output width per product, so the nine-term sum cannot wrap
    // R13 nine products in tap order
    for (int i = 0; i < NT; i++)
    begin
      cur = (i == 0) ? in_sample : hist_q[i-1];
      smp = OUT_W'(cur);
      // R1 R4 sign-extend each weight field
      if (i == fir_bank_pkg::CENTER_TAP)
      begin
        coef = OUT_W'(signed'(tap_q[i][fir_bank_pkg::CENTER_W-1:0]));
      end
      else
      begin
        // R2 R12 twelve-bit weights
        coef = OUT_W'(signed'(tap_q[i][fir_bank_pkg::TAP_W-1:0]));
      end
      acc_d = acc_d + OUT_W'(coef * smp);
    end
    for (int i = 0; i < NT - 1; i++)
    begin
      hist_d[i] = hist_q[i];
    end
    // History moves only on a sample strobe, so gaps in the stream are harmless
    if (in_valid)
    begin
      hist_d[0] = in_sample;
      for (int i = 1; i < NT - 1; i++)
      begin
        hist_d[i] = hist_q[i-1];
      end
    end
    out_valid_d = in_valid;
    out_sample_d = in_valid ? acc_d : out_sample;
    // R7 mode only tags the output; weights are shared
    out_single_d = in_valid ? single_channel_mode : out_single;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      for (int i = 0; i < NT - 1; i++)
      begin
        hist_q[i] <= '0;
      end
      out_valid <= 1'b0;
      out_single <= 1'b0;
      out_sample <= '0;
    end
    else
    begin
      for (int i = 0; i < NT - 1; i++)
      begin
        hist_q[i] <= hist_d[i];
      end
      out_valid <= out_valid_d;
      out_single <= out_single_d;
      out_sample <= out_sample_d;
    end
  end

endmodule // fir_tap_coeff_bank_a

`default_nettype wire

// ==== fir_bank_a_assertions.sv ====
`default_nettype none
// ****
// Port checks of the tap bank
// ****
module fir_bank_a_checker #(
  parameter int SAMPLE_W = 8
) (
  input wire logic                        clk,
  input wire logic                        reset,
  input wire fir_bank_pkg::reg_req_s      reg_req,
  input wire logic [7:0]                  rd_data,
  input wire logic                        rd_valid,
  input wire logic                        single_channel_mode,
  input wire logic                        in_valid,
  input wire logic signed [SAMPLE_W-1:0]  in_sample,
  input wire logic                        out_valid,
  input wire logic                        out_single,
  input wire logic signed [SAMPLE_W+21:0] out_sample
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_rd_req;
    reg_req.rd;
  endsequence
  sequence s_rd_ans;
    rd_valid;
  endsequence
  a_rd_answer: assert property (s_rd_req |=> s_rd_ans)
    else $error("read not answered");
  a_rd_quiet: assert property (!reg_req.rd |=> !rd_valid && rd_data == 8'h00)
    else $error("read data without read");
  a_unmapped_zero: assert property (reg_req.rd && reg_req.addr == 12'h42b |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
  // Reset must not mask its own check
  a_reset_clear: assert property (disable iff (1'b0) $fell(reset) |->
    !out_valid && !rd_valid && out_sample == '0) else $error("outputs not cleared");
  a_out_follows: assert property (in_valid |=> out_valid)
    else $error("sample not answered");
  a_out_quiet: assert property (!in_valid |=> !out_valid)
    else $error("spurious out_valid");
  a_out_hold: assert property (!in_valid |=> $stable(out_sample))
    else $error("output not held");
  a_mode_copy: assert property (in_valid |=> out_single == $past(single_channel_mode))
    else $error("mode flag wrong");
endmodule // fir_bank_a_checker

bind fir_tap_coeff_bank_a fir_bank_a_checker #(.SAMPLE_W(SAMPLE_W)) chk_i (.clk, .reset,
  .reg_req, .rd_data, .rd_valid, .single_channel_mode, .in_valid, .in_sample, .out_valid,
  .out_single, .out_sample);
`default_nettype wire

// ==== fir_tap_coeff_bank_a_bench.sv ====
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("[ERR] %0t %h %h", $time, a, e); end end
module fir_tap_coeff_bank_a_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = '0, reset = '1, single_channel_mode = '0, in_valid = '0, out_valid, out_single;
  logic rd_valid;
  logic [7:0] rd_data;
  logic signed [7:0] in_sample = '0;
  logic signed [29:0] out_sample;
  fir_bank_pkg::reg_req_s reg_req = '0;
  logic [23:0] img [9] = '{default: '0};
  logic signed [7:0] hist [9] = '{default: '0};
  int error_cnt = 0, num_checks = 0, rnd;
  always #12.5 clk = ~clk;
  fir_tap_coeff_bank_a fir_tap_coeff_bank_a_i (.clk, .reset, .reg_req, .rd_data, .rd_valid,
    .single_channel_mode, .in_valid, .in_sample, .out_valid, .out_single, .out_sample);
  // Centre weight is 18 bits wide, the others 12
  function automatic logic signed [29:0] fir_exp();
    logic signed [29:0] s;
    s = '0;
    for (int i = 0; i < 9; i++)
      s += hist[i] * (i == 4 ? $signed(img[i][17:0]) : $signed(img[i][11:0]));
    return s;
  endfunction
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk) reg_req <= '{1'b1, 1'b0, a, d};
    @(posedge clk) reg_req <= '0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk) reg_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk) reg_req <= '0;
    @(negedge clk) `CHK(rd_data, e)
    `CHK(rd_valid, 1'b1)
  endtask
  task automatic final_report();
    if (error_cnt == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    rnd = $urandom(32'h1d6c);
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    // Negative centre weight with reserved bits set is the corner case
    for (int t = 0; t < 9; t++)
      for (int b = 0; b < (t == 4 ? 3 : 2); b++)
      begin
        rd(fir_bank_pkg::TAP_ADDR[t] + 12'(b), 8'h00);
        img[t][8*b +: 8] = (t == 4 && b == 2) ? 8'hfe : 8'($urandom);
        wr(fir_bank_pkg::TAP_ADDR[t] + 12'(b), img[t][8*b +: 8]);
        rd(fir_bank_pkg::TAP_ADDR[t] + 12'(b), img[t][8*b +: 8]);
      end
    wr(12'h42b, 8'h5a);
    rd(12'h42b, 8'h00);
    for (int n = 0; n < 60; n++)
    begin
      for (int i = 8; i > 0; i--)
        hist[i] = hist[i-1];
      hist[0] = n < 3 ? 8'sh80 : 8'($urandom);
      @(posedge clk);
      in_valid <= 1'b1;
      in_sample <= hist[0];
      single_channel_mode <= n[0];
      @(posedge clk) in_valid <= 1'b0;
      @(negedge clk) `CHK(out_sample, fir_exp())
      `CHK(out_single, n[0])
      `CHK(out_valid, 1'b1)
    end
    @(posedge clk) reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk) `CHK(out_sample, 30'h0)
    rd(12'h422, 8'h00);
    rd(12'h423, 8'h00);
    rd(12'h425, 8'h00);
    final_report();
  end
endmodule // fir_tap_coeff_bank_a_bench
`default_nettype wire
